// ==== rtl/masc_pkg.sv ====
// package: register map, field layout and codes for the step configuration block
package masc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] STEP_FOUR_ADDR = 8'h94;
    localparam logic [ADDR_W-1:0] STEP_FIVE_ADDR = 8'h95;
    localparam logic [ADDR_W-1:0] SEQ_CTRL_ADDR = 8'hA0;
    localparam logic [ADDR_W-1:0] SEQ_STAT_ADDR = 8'hA1;
    localparam logic [DATA_W-1:0] STEP_FOUR_RESET = 16'h0004;
    localparam logic [DATA_W-1:0] STEP_FIVE_RESET = 16'h0005;
    localparam logic [DATA_W-1:0] WRITABLE_MASK = 16'hE01F;
    localparam int EN_BIT = 15;
    localparam int GAIN_HI = 14;
    localparam int GAIN_LO = 13;
    localparam int NEG_BIT = 4;
    localparam int POS_HI = 3;
    localparam int POS_LO = 0;
    localparam int CTRL_START_BIT = 0;
    localparam logic [1:0] GAIN_X1 = 2'h0;
    localparam logic [1:0] GAIN_X2 = 2'h1;
    localparam logic [2:0] GAIN_MUL1 = 3'h1;
    localparam logic [2:0] GAIN_MUL2 = 3'h2;
    localparam logic [2:0] GAIN_MUL4 = 3'h4;
    localparam logic [3:0] POS_EXT_MAX = 4'h7;
    localparam logic [3:0] POS_ZERO_CODE = 4'h0;
    // negative input codes presented to the converter mux
    localparam logic [1:0] NEG_GROUND = 2'h0;
    localparam logic [1:0] NEG_EXT_SEVEN = 2'h1;
    localparam logic [1:0] NEG_AUTO = 2'h2;
    localparam logic [1:0] NEG_SEL_INPUT7 = 2'h1;
    typedef enum logic [1:0] {
        MASC_IDLE = 2'b00,
        MASC_FOUR = 2'b01,
        MASC_FIVE = 2'b11
    } masc_state_t;
endpackage

// ==== rtl/masc_step_config.sv ====
// step four and five configuration registers with a small two-step sequencer
// Operation
// - bit 15 includes step four in sequence
// - bits 14:13 pick gain 1, 2, 4
// - bits 12:5 read as zero
// - bit 4 negative: ground or input seven
// - codes 0 to 7 pick external inputs
// - codes 8 and up internal, auto negative
// - auto negative ignores negative select bit
// - step five at 95h, resets 0005h
// - step four positive resets to input four
// - step four at 94h, resets 0004h
`timescale 1ns/1ps
module masc_step_config (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [masc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [masc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic step_done_i,
    output logic [masc_pkg::DATA_W-1:0] rdata_o,
    output logic step_active_o,
    output logic step_index_o,
    output logic [2:0] gain_mul_o,
    output logic [3:0] positive_input_o,
    output logic [1:0] negative_input_o
);
    import masc_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] four;
        logic [DATA_W-1:0] five;
        logic [DATA_W-1:0] rdata;
        masc_state_t st;
        logic active;
        logic index;
        logic [2:0] gain;
        logic [3:0] pos;
        logic [1:0] neg;
    } masc_regs_t;

    masc_regs_t s_r;
    masc_regs_t s_nxt;

    function automatic logic [2:0] gain_of(input logic [1:0] code);
        case (code)
            GAIN_X1: gain_of = GAIN_MUL1;
            GAIN_X2: gain_of = GAIN_MUL2;
            default: gain_of = GAIN_MUL4;
        endcase
    endfunction

    // codes above seven route internal sources, negative mux takes over
    function automatic logic [1:0] neg_of(input logic [DATA_W-1:0] cfg);
        if (cfg[POS_HI:POS_LO] > POS_EXT_MAX) begin
            neg_of = NEG_AUTO;
        end else if (cfg[NEG_BIT]) begin
            neg_of = NEG_EXT_SEVEN;
        end else begin
            neg_of = NEG_GROUND;
        end
    endfunction

    always_comb begin
        logic [DATA_W-1:0] cfg;
        logic start;
        cfg = '0;
        start = wr_i && addr_i == SEQ_CTRL_ADDR && wdata_i[CTRL_START_BIT];
        s_nxt = s_r;
        s_nxt.rdata = '0;
        if (wr_i && addr_i == STEP_FOUR_ADDR) begin
            s_nxt.four = wdata_i & WRITABLE_MASK;
        end
        if (wr_i && addr_i == STEP_FIVE_ADDR) begin
            s_nxt.five = wdata_i & WRITABLE_MASK;
        end
        if (rd_i) begin
            case (addr_i)
                STEP_FOUR_ADDR: s_nxt.rdata = s_r.four;
                STEP_FIVE_ADDR: s_nxt.rdata = s_r.five;
                SEQ_STAT_ADDR: s_nxt.rdata = {{(DATA_W-2){1'b0}}, s_r.index, s_r.active};
                default: s_nxt.rdata = '0;
            endcase
        end
        // disabled steps are skipped; a pass with none enabled stays idle
        case (s_r.st)
            MASC_IDLE: begin
                if (start) begin
                    if (s_r.four[EN_BIT]) begin
                        s_nxt.st = MASC_FOUR;
                    end else if (s_r.five[EN_BIT]) begin
                        s_nxt.st = MASC_FIVE;
                    end
                end
            end
            MASC_FOUR: begin
                if (step_done_i) begin
                    s_nxt.st = s_r.five[EN_BIT] ? MASC_FIVE : MASC_IDLE;
                end
            end
            MASC_FIVE: begin
                if (step_done_i) begin
                    s_nxt.st = MASC_IDLE;
                end
            end
            default: s_nxt.st = MASC_IDLE;
        endcase
        // settings are latched from the register the step uses
        s_nxt.active = s_nxt.st != MASC_IDLE;
        s_nxt.index = s_nxt.st == MASC_FIVE;
        if (s_nxt.st == MASC_FOUR) begin
            cfg = s_r.four;
        end else if (s_nxt.st == MASC_FIVE) begin
            cfg = s_r.five;
        end
        // latch only on step entry so a register write mid-step cannot disturb the mux
        if (!s_nxt.active) begin
            s_nxt.gain = GAIN_MUL1;
            s_nxt.pos = POS_ZERO_CODE;
            s_nxt.neg = NEG_GROUND;
        end else if (s_nxt.st != s_r.st) begin
            s_nxt.gain = gain_of(cfg[GAIN_HI:GAIN_LO]);
            s_nxt.pos = cfg[POS_HI:POS_LO];
            s_nxt.neg = neg_of(cfg);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_r.four <= STEP_FOUR_RESET;
            s_r.five <= STEP_FIVE_RESET;
            s_r.rdata <= '0;
            s_r.st <= MASC_IDLE;
            s_r.active <= 1'b0;
            s_r.index <= 1'b0;
            s_r.gain <= GAIN_MUL1;
            s_r.pos <= POS_ZERO_CODE;
            s_r.neg <= NEG_GROUND;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign step_active_o = s_r.active;
    assign step_index_o = s_r.index;
    assign gain_mul_o = s_r.gain;
    assign positive_input_o = s_r.pos;
    assign negative_input_o = s_r.neg;

    // bus and start patterns shared by the checks below
    sequence rd_four_s;
        rd_i && addr_i == STEP_FOUR_ADDR;
    endsequence
    sequence rd_five_s;
        rd_i && addr_i == STEP_FIVE_ADDR;
    endsequence
    sequence wr_four_s;
        wr_i && addr_i == STEP_FOUR_ADDR;
    endsequence
    sequence wr_five_s;
        wr_i && addr_i == STEP_FIVE_ADDR;
    endsequence
    sequence start_four_s;
        s_r.st == MASC_IDLE && wr_i && addr_i == SEQ_CTRL_ADDR && wdata_i[CTRL_START_BIT] && s_r.four[EN_BIT];
    endsequence
    sequence start_five_s;
        s_r.st == MASC_IDLE && wr_i && addr_i == SEQ_CTRL_ADDR && wdata_i[CTRL_START_BIT] && !s_r.four[EN_BIT] &&
            s_r.five[EN_BIT];
    endsequence
    sequence start_none_s;
        s_r.st == MASC_IDLE && wr_i && addr_i == SEQ_CTRL_ADDR && wdata_i[CTRL_START_BIT] && !s_r.four[EN_BIT] &&
            !s_r.five[EN_BIT];
    endsequence

    a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_four_s |=> (rdata_o & ~WRITABLE_MASK) == '0)
        else $error("reserved bits read nonzero");
    a_reserved_five: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_five_s |=> (rdata_o & ~WRITABLE_MASK) == '0)
        else $error("step five reserved bits read nonzero");
    a_four_store: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_four_s |=> (s_r.four & ~WRITABLE_MASK) == '0)
        else $error("reserved bits stored in step four");
    a_five_store: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_five_s |=> (s_r.five & ~WRITABLE_MASK) == '0)
        else $error("reserved bits stored in step five");
    a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == '0)
        else $error("read data not cleared");
    a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_i && addr_i != STEP_FOUR_ADDR && addr_i != STEP_FIVE_ADDR && addr_i != SEQ_STAT_ADDR |=>
            rdata_o == '0)
        else $error("unmapped read nonzero");
    a_status_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_i && addr_i == SEQ_STAT_ADDR |=> rdata_o[1:0] == {$past(step_index_o), $past(step_active_o)} &&
            rdata_o[DATA_W-1:2] == '0)
        else $error("status read wrong");
    a_four_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(wr_i && addr_i == STEP_FOUR_ADDR) |=> $stable(s_r.four))
        else $error("step four changed without write");
    a_five_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(wr_i && addr_i == STEP_FIVE_ADDR) |=> $stable(s_r.five))
        else $error("step five changed without write");
    a_write_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_four_s ##1 rd_four_s |=> rdata_o == ($past(wdata_i, 2) & WRITABLE_MASK))
        else $error("step four write not read back");
    a_write_five: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_five_s ##1 rd_five_s |=> rdata_o == ($past(wdata_i, 2) & WRITABLE_MASK))
        else $error("step five write not read back");

    a_four_reset_val: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) |-> s_r.four == STEP_FOUR_RESET)
        else $error("step four reset value wrong");
    a_five_reset_val: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) |-> s_r.five == STEP_FIVE_RESET)
        else $error("step five reset value wrong");
    a_four_fields_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) |-> !s_r.four[EN_BIT] && s_r.four[GAIN_HI:GAIN_LO] == GAIN_X1 && !s_r.four[NEG_BIT] &&
            s_r.four[POS_HI:POS_LO] == STEP_FOUR_RESET[POS_HI:POS_LO])
        else $error("step four fields reset wrong");
    a_four_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_four_s ##0 $past(rst_i) |=> rdata_o == STEP_FOUR_RESET)
        else $error("step four reset readback wrong");
    a_five_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_five_s ##0 $past(rst_i, 3) && !$past(wr_i) && !$past(wr_i, 2) |=>
            rdata_o == STEP_FIVE_RESET)
        else $error("step five reset readback wrong");

    a_start_four: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s |=> step_active_o && !step_index_o)
        else $error("enabled step four not started");
    a_start_five: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_five_s |=> step_active_o && step_index_o)
        else $error("disabled step four not skipped");
    a_start_none: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_none_s |=> !step_active_o)
        else $error("start with no step enabled ran");
    a_no_self_start: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_r.st == MASC_IDLE && !(wr_i && addr_i == SEQ_CTRL_ADDR && wdata_i[CTRL_START_BIT]) |=>
            !step_active_o)
        else $error("sequencer left idle without start");
    a_busy_ignore: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        step_active_o && !step_done_i |=> step_active_o && $stable(step_index_o))
        else $error("step left before done");
    a_four_to_five: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        step_active_o && !step_index_o && step_done_i && s_r.five[EN_BIT] |=> step_active_o && step_index_o)
        else $error("step five not entered");
    a_four_to_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        step_active_o && !step_index_o && step_done_i && !s_r.five[EN_BIT] |=> !step_active_o)
        else $error("disabled step five not skipped");
    a_five_to_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        step_active_o && step_index_o && step_done_i |=> !step_active_o)
        else $error("sequence did not end");
    a_latched_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        step_active_o && !step_done_i |=> $stable(gain_mul_o) && $stable(positive_input_o) &&
            $stable(negative_input_o))
        else $error("settings changed mid step");

    a_gain_x1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s ##0 s_r.four[GAIN_HI:GAIN_LO] == GAIN_X1 |=> gain_mul_o == GAIN_MUL1)
        else $error("gain code 0 wrong");
    a_gain_x2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s ##0 s_r.four[GAIN_HI:GAIN_LO] == GAIN_X2 |=> gain_mul_o == GAIN_MUL2)
        else $error("gain code 1 wrong");
    a_gain_x4: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s ##0 s_r.four[GAIN_HI] |=> gain_mul_o == GAIN_MUL4)
        else $error("gain codes 2 and 3 wrong");
    a_four_pos_route: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s |=> positive_input_o == $past(s_r.four[POS_HI:POS_LO]))
        else $error("step four positive input wrong");
    a_neg_ground: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s ##0 s_r.four[POS_HI:POS_LO] <= POS_EXT_MAX && !s_r.four[NEG_BIT] |=>
            negative_input_o == NEG_GROUND)
        else $error("negative ground not selected");
    a_neg_seven: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s ##0 s_r.four[POS_HI:POS_LO] <= POS_EXT_MAX && s_r.four[NEG_BIT] |=>
            negative_input_o == NEG_EXT_SEVEN)
        else $error("negative input seven not selected");
    a_internal_auto: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_four_s ##0 s_r.four[POS_HI:POS_LO] > POS_EXT_MAX |=>
            negative_input_o == NEG_AUTO && positive_input_o > POS_EXT_MAX)
        else $error("internal source routing wrong");
    a_gain_map: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(step_index_o) |-> gain_mul_o == ($past(s_r.five[GAIN_HI]) ? GAIN_MUL4 :
            $past(s_r.five[GAIN_LO]) ? GAIN_MUL2 : GAIN_MUL1))
        else $error("gain mapping wrong");
    a_five_pos: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(step_index_o) |-> positive_input_o == $past(s_r.five[POS_HI:POS_LO]))
        else $error("step five positive input wrong");
    a_idle_index: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !step_active_o |-> !step_index_o && negative_input_o == NEG_GROUND)
        else $error("idle index or negative not parked");
    a_auto_negative: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        step_active_o && positive_input_o > POS_EXT_MAX |-> negative_input_o == NEG_AUTO)
        else $error("negative select not ignored");
    a_ext_negative: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        step_active_o && positive_input_o <= POS_EXT_MAX |-> negative_input_o != NEG_AUTO)
        else $error("external negative missing");
    a_skip_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_r.st == MASC_IDLE && !s_r.four[EN_BIT] |=> !(step_active_o && !step_index_o))
        else $error("disabled step four ran");
    a_pos_route: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !step_active_o |-> positive_input_o == POS_ZERO_CODE && gain_mul_o == GAIN_MUL1)
        else $error("idle outputs not parked");
endmodule

// ==== dv/tb_masc_step_config.sv ====
// self-checking testbench for the step configuration block
`timescale 1ns/1ps
module tb_masc_step_config;
    import masc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic step_done_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic step_active_o;
    logic step_index_o;
    logic [2:0] gain_mul_o;
    logic [3:0] positive_input_o;
    logic [1:0] negative_input_o;
    int n_mismatch = 0;
    int checks = 0;
    masc_step_config masc_step_config_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .step_done_i(step_done_i), .rdata_o(rdata_o),
        .step_active_o(step_active_o), .step_index_o(step_index_o), .gain_mul_o(gain_mul_o),
        .positive_input_o(positive_input_o), .negative_input_o(negative_input_o));
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a gap cycle after each strobe keeps one assignment per signal per time step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_cmp(input logic [7:0] a, input logic [15:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 cmp(rdata_o, exp);
        @(posedge ref_clk_i);
    endtask
    task automatic chk(input logic act, input logic idx, input logic [2:0] g, input logic [3:0] p,
                       input logic [1:0] n);
        #1 cmp({15'h0, step_active_o}, {15'h0, act});
        cmp({15'h0, step_index_o}, {15'h0, idx});
        cmp({13'h0, gain_mul_o}, {13'h0, g});
        cmp({12'h0, positive_input_o}, {12'h0, p});
        cmp({14'h0, negative_input_o}, {14'h0, n});
        @(posedge ref_clk_i);
    endtask
    task automatic done;
        step_done_i <= 1'b1;
        @(posedge ref_clk_i);
        step_done_i <= 1'b0;
    endtask
    task automatic test_regs;
        rd_cmp(STEP_FOUR_ADDR, 16'h0004);
        rd_cmp(STEP_FIVE_ADDR, 16'h0005);
        chk(1'b0, 1'b0, 3'h1, 4'h0, 2'h0);
        rd_cmp(8'h33, 16'h0000);
        rd_cmp(SEQ_STAT_ADDR, 16'h0000);
        wr(STEP_FOUR_ADDR, 16'hFFFF);
        rd_cmp(STEP_FOUR_ADDR, 16'hE01F);
        wr(STEP_FIVE_ADDR, 16'hFFFF);
        rd_cmp(STEP_FIVE_ADDR, 16'hE01F);
        $display("test_regs done");
    endtask
    // strobes back to back: a read right behind a write sees the new value
    task automatic test_b2b;
        addr_i <= STEP_FOUR_ADDR;
        wdata_i <= 16'h8A35;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        addr_i <= STEP_FIVE_ADDR;
        wdata_i <= 16'h7FEA;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        #1 cmp(rdata_o, 16'h8015);
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        #1 cmp(rdata_o, 16'h0000);
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 cmp(rdata_o, 16'h600A);
        @(posedge ref_clk_i);
        $display("test_b2b done");
    endtask
    // every positive code, every gain code, both negative select values
    task automatic test_codes;
        logic [3:0] p;
        logic [1:0] g;
        logic [2:0] gm;
        wr(STEP_FIVE_ADDR, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            p = 4'(i);
            g = 2'(i);
            gm = (g == 2'h0) ? 3'h1 : (g == 2'h1) ? 3'h2 : 3'h4;
            wr(STEP_FOUR_ADDR, {1'b1, g, 8'h00, i[2], p});
            wr(SEQ_CTRL_ADDR, 16'h0001);
            chk(1'b1, 1'b0, gm, p, (p > 4'h7) ? 2'h2 : {1'b0, i[2]});
            done();
            chk(1'b0, 1'b0, 3'h1, 4'h0, 2'h0);
        end
        $display("test_codes done");
    endtask
    task automatic test_skip;
        wr(STEP_FOUR_ADDR, 16'h4013);
        wr(STEP_FIVE_ADDR, 16'hA005);
        wr(SEQ_CTRL_ADDR, 16'h0001);
        chk(1'b1, 1'b1, 3'h2, 4'h5, 2'h0);
        rd_cmp(SEQ_STAT_ADDR, 16'h0003);
        done();
        chk(1'b0, 1'b0, 3'h1, 4'h0, 2'h0);
        wr(STEP_FOUR_ADDR, 16'hC012);
        wr(SEQ_CTRL_ADDR, 16'h0001);
        chk(1'b1, 1'b0, 3'h4, 4'h2, 2'h1);
        wr(SEQ_CTRL_ADDR, 16'h0001);
        wr(STEP_FOUR_ADDR, 16'hC013);
        chk(1'b1, 1'b0, 3'h4, 4'h2, 2'h1);
        done();
        chk(1'b1, 1'b1, 3'h2, 4'h5, 2'h0);
        done();
        chk(1'b0, 1'b0, 3'h1, 4'h0, 2'h0);
        wr(STEP_FOUR_ADDR, 16'h0004);
        wr(STEP_FIVE_ADDR, 16'h0005);
        wr(SEQ_CTRL_ADDR, 16'h0001);
        chk(1'b0, 1'b0, 3'h1, 4'h0, 2'h0);
        $display("test_skip done");
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        test_regs();
        test_b2b();
        test_codes();
        test_skip();
        print_verdict();
    end
endmodule
